// ==== wmt_host.sv ====
// partner model: two-wire bus host, timing unrelated to the system clock
`timescale 1ns/100ps
module wmt_host (
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_m
);
  // idle bus: both lines released high
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end
  // data moves only while scl low
  task bitx(input logic b, output logic r);
    #20 sda_m = b;
    #42.5 scl = 1'b1;
    #62.5 r = sda_w;
    scl = 1'b0;
  endtask
  task start;
    sda_m = 1'b1;
    #62.5 scl = 1'b1;
    #62.5 sda_m = 1'b0;
    #62.5 scl = 1'b0;
  endtask
  task stop;
    #20 sda_m = 1'b0;
    #42.5 scl = 1'b1;
    #62.5 sda_m = 1'b1;
    #62.5;
  endtask
  task xbyte(input logic [7:0] d, input logic ain, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ain, a);
    ack = ~a;
  endtask
endmodule

// ==== wmt_map.vh ====
// constants and field positions of the wake-up match timer
// Functional notes
// - The timer is a 24-bit binary counter that only counts upward.
// - The counter is compared with the stored wake-up time and the interrupt rises when they become equal.
// - The counter advances once per second, giving wake-up delays from one second to about 194 days.
// - All timekeeping comes from the 32.768 kHz crystal oscillator input.
// - While the timer reset pin is low the counter stays cleared, and it counts once the pin is high.
// - Bounces on the timer reset pin are filtered so they cause no spurious reset or start.
// - The host loads the wake-up time over the two-wire bus and the device holds it.
// - Bits move in step with the host clock on SCL, the device receiving and sending on SDA.
// - The device only pulls SDA low or releases it, never drives it high.
// - The interrupt stays active after a match until the host performs the acknowledging read or the filtered timer reset pin goes low.
`ifndef WMT_MAP_VH
`define WMT_MAP_VH

// ==========================================================
// timer
`define WMT_CNT_W     24
`define WMT_OSC_HZ    32768
`define WMT_SEC_S     1
`define WMT_PRE_DIV   (`WMT_OSC_HZ * `WMT_SEC_S)
`define WMT_PRE_W     15
`define WMT_CNT_RST   24'h000000
`define WMT_WAKE_RST  24'hffffff

// ==========================================================
// timer reset filter, in oscillator periods
`define WMT_DEB_N     3'h4
`define WMT_DEB_W     3

// ==========================================================
// serial bus
`define WMT_I2C_ADDR  7'h32
`define WMT_BYTE_HI   2'h0
`define WMT_BYTE_MID  2'h1
`define WMT_BYTE_LO   2'h2
`define WMT_BIT_LAST  4'h8

`endif

// ==== wmt_top.v ====
// wake-up match timer: oscillator prescaler, 24-bit counter, two-wire slave
`timescale 1ns/100ps
`include "wmt_map.vh"

module wmt_top (
  input  wire clock,
  input  wire arst_n,
  input  wire osc_in,
  input  wire tmr_rst_n,
  input  wire scl_in,
  input  wire sda_in,
  output wire sda_out,
  output wire sda_oe,
  output wire int_out
);

  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_AACK = 3'h2;
  localparam [2:0] ST_WDAT = 3'h3;
  localparam [2:0] ST_WACK = 3'h4;
  localparam [2:0] ST_RDAT = 3'h5;
  localparam [2:0] ST_RACK = 3'h6;

  // ==========================================================
  // reset release
  reg                  rst_s1_r;
  reg                  rst_s2_r;
  wire                 rst_n;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1_r <= 1'b0;
      rst_s2_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_s2_r <= rst_s1_r;
    end
  end
  assign rst_n = rst_s2_r;

  // ==========================================================
  // pin synchronisers: osc, timer reset, scl, sda
  reg  [3:0]           sync1_r;
  reg  [3:0]           sync2_r;
  reg                  osc_d_r;
  reg                  scl_d_r;
  reg                  sda_d_r;
  wire                 osc_s;
  wire                 trst_s;
  wire                 scl_s;
  wire                 sda_s;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 4'hf;
      sync2_r <= 4'hf;
      osc_d_r <= 1'b1;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      sync1_r <= {sda_in, scl_in, tmr_rst_n, osc_in};
      sync2_r <= sync1_r;
      osc_d_r <= osc_s;
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end
  assign osc_s  = sync2_r[0];
  assign trst_s = sync2_r[1];
  assign scl_s  = sync2_r[2];
  assign sda_s  = sync2_r[3];

  wire                 osc_tick = osc_s & ~osc_d_r;
  wire                 scl_rise = scl_s & ~scl_d_r;
  wire                 scl_fall = ~scl_s & scl_d_r;
  wire                 i2c_start = scl_s & scl_d_r & ~sda_s & sda_d_r;
  wire                 i2c_stop  = scl_s & scl_d_r & sda_s & ~sda_d_r;

  // ==========================================================
  // timer reset chatter filter
  reg                  run_r;
  reg  [`WMT_DEB_W-1:0] deb_r;

  // needs stable level for several osc periods
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      run_r <= 1'b0;
      deb_r <= {`WMT_DEB_W{1'b0}};
    end else if (osc_tick) begin
      if (trst_s == run_r) begin
        deb_r <= {`WMT_DEB_W{1'b0}};
      end else if (deb_r == `WMT_DEB_N - 3'h1) begin
        run_r <= trst_s;
        deb_r <= {`WMT_DEB_W{1'b0}};
      end else begin
        deb_r <= deb_r + 3'h1;
      end
    end
  end

  // ==========================================================
  // prescaler and seconds counter
  reg  [`WMT_PRE_W-1:0] pre_r;
  reg  [`WMT_CNT_W-1:0] cnt_r;
  reg  [`WMT_CNT_W-1:0] wake_r;
  reg                  int_r;
  reg                  int_clr_r;
  wire                 sec_tick;
  wire [`WMT_CNT_W-1:0] cnt_nxt;

  assign sec_tick = run_r & osc_tick & (pre_r == `WMT_PRE_DIV - 1);
  assign cnt_nxt  = cnt_r + 24'h000001;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pre_r <= {`WMT_PRE_W{1'b0}};
      cnt_r <= `WMT_CNT_RST;
    end else if (!run_r) begin
      pre_r <= {`WMT_PRE_W{1'b0}};
      cnt_r <= `WMT_CNT_RST;
    end else if (osc_tick) begin
      pre_r <= pre_r + 15'h0001;
      if (sec_tick) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // a match set wins over a host clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      int_r <= 1'b0;
    end else if (!run_r) begin
      int_r <= 1'b0;
    end else if (sec_tick && cnt_nxt == wake_r) begin
      int_r <= 1'b1;
    end else if (int_clr_r) begin
      int_r <= 1'b0;
    end
  end

  // ==========================================================
  // two-wire slave
  reg  [2:0]           st_r;
  reg  [3:0]           bit_r;
  reg  [1:0]           byte_r;
  reg  [7:0]           rx_r;
  reg  [7:0]           tx_r;
  reg  [15:0]          wbuf_r;
  reg  [`WMT_CNT_W-1:0] snap_r;
  reg                  oe_r;
  reg                  ack_r;
  reg  [7:0]           tx_sel;
  wire [1:0]           byte_inc;
  wire [1:0]           byte_sel;

  assign byte_inc = (byte_r == `WMT_BYTE_LO) ? `WMT_BYTE_HI : byte_r + 2'h1;
  // byte after a host ack comes from the index that ack moves to
  assign byte_sel = (st_r == ST_RACK) ? byte_inc : byte_r;

  always @* begin
    case (byte_sel)
      `WMT_BYTE_HI:  tx_sel = snap_r[23:16];
      `WMT_BYTE_MID: tx_sel = snap_r[15:8];
      default:       tx_sel = snap_r[7:0];
    endcase
  end

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r    <= ST_IDLE;
      bit_r   <= 4'h0;
      byte_r  <= 2'h0;
      rx_r    <= 8'h00;
      tx_r    <= 8'h00;
      wbuf_r  <= 16'h0000;
      snap_r  <= `WMT_CNT_RST;
      wake_r  <= `WMT_WAKE_RST;
      oe_r    <= 1'b0;
      ack_r   <= 1'b0;
      int_clr_r <= 1'b0;
    end else begin
      int_clr_r <= 1'b0;
      if (i2c_start) begin
        st_r   <= ST_ADDR;
        bit_r  <= 4'h0;
        byte_r <= 2'h0;
        oe_r   <= 1'b0;
      end else if (i2c_stop) begin
        st_r <= ST_IDLE;
        oe_r <= 1'b0;
      end else if (scl_rise) begin
        if (st_r == ST_ADDR || st_r == ST_WDAT) begin
          rx_r  <= {rx_r[6:0], sda_s};
          bit_r <= bit_r + 4'h1;
        end
        if (st_r == ST_RACK) begin
          ack_r <= ~sda_s;
        end
      end else if (scl_fall) begin
        // change sda only while scl low
        case (st_r)
          ST_ADDR: begin
            if (bit_r == `WMT_BIT_LAST) begin
              if (rx_r[7:1] == `WMT_I2C_ADDR) begin
                oe_r <= 1'b1;
                st_r <= ST_AACK;
                if (rx_r[0]) begin
                  snap_r  <= cnt_r;
                  int_clr_r <= 1'b1;
                end
              end else begin
                st_r <= ST_IDLE;
              end
            end
          end
          ST_AACK: begin
            bit_r <= 4'h0;
            if (rx_r[0]) begin
              // drive low only, release for ones
              oe_r  <= ~tx_sel[7];
              tx_r  <= {tx_sel[6:0], 1'b0};
              bit_r <= 4'h1;
              st_r  <= ST_RDAT;
            end else begin
              oe_r <= 1'b0;
              st_r <= ST_WDAT;
            end
          end
          ST_WDAT: begin
            if (bit_r == `WMT_BIT_LAST) begin
              oe_r <= 1'b1;
              st_r <= ST_WACK;
              // high byte first, commit on third
              if (byte_r == `WMT_BYTE_LO) begin
                wake_r <= {wbuf_r, rx_r};
              end else begin
                wbuf_r <= {wbuf_r[7:0], rx_r};
              end
            end
          end
          ST_WACK: begin
            oe_r   <= 1'b0;
            bit_r  <= 4'h0;
            byte_r <= byte_inc;
            st_r   <= ST_WDAT;
          end
          ST_RDAT: begin
            if (bit_r == `WMT_BIT_LAST) begin
              oe_r <= 1'b0;
              st_r <= ST_RACK;
            end else begin
              oe_r  <= ~tx_r[7];
              tx_r  <= {tx_r[6:0], 1'b0};
              bit_r <= bit_r + 4'h1;
            end
          end
          ST_RACK: begin
            if (ack_r) begin
              oe_r   <= ~tx_sel[7];
              tx_r   <= {tx_sel[6:0], 1'b0};
              bit_r  <= 4'h1;
              st_r   <= ST_RDAT;
            end else begin
              oe_r <= 1'b0;
              st_r <= ST_IDLE;
            end
          end
          default: begin
            oe_r <= 1'b0;
          end
        endcase
        if (st_r == ST_RACK && ack_r) begin
          byte_r <= byte_inc;
        end
      end
    end
  end

  // data line level driven is always low; only enable moves
  reg                  sda_lvl_r;
  reg                  int_out_r;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_lvl_r <= 1'b0;
      int_out_r <= 1'b0;
    end else begin
      sda_lvl_r <= 1'b0;
      int_out_r <= int_r;
    end
  end

  assign sda_out = sda_lvl_r;
  assign sda_oe  = oe_r;
  assign int_out = int_out_r;

endmodule

// ==== wmt_top_asserts.sv ====
// checker: port-level properties of the wake-up match timer
`timescale 1ns/100ps
module wmt_top_asserts (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic osc_in,
  input wire logic tmr_rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic int_out
);
  // ==========================================
  // helper: cycles the timer reset pin has been low
  logic [5:0] low_cnt_r;
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) low_cnt_r <= 6'h00;
    else if (tmr_rst_n) low_cnt_r <= 6'h00;
    else if (low_cnt_r != 6'h3f) low_cnt_r <= low_cnt_r + 6'h01;
  end
  // ==========================================
  // properties
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  AST_SDA_NEVER_HIGH: assert property (sda_out == 1'b0)
    else $error("sda driven high");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda drive changed while scl high");
  AST_OE_BOUNDED: assert property ($rose(sda_oe) |-> ##[1:400] !sda_oe)
    else $error("sda held low too long");
  AST_INT_NEEDS_RUN: assert property ($rose(int_out) |-> tmr_rst_n)
    else $error("interrupt rose while timer held in reset");
  AST_INT_HOLDS: assert property ($rose(int_out) |=> int_out [*8])
    else $error("interrupt dropped early");
  AST_INT_FALL_CAUSE: assert property ($fell(int_out) |-> (!scl_in || !tmr_rst_n))
    else $error("interrupt fell without handshake");
  AST_RST_CLEARS_INT: assert property (low_cnt_r >= 6'h1e |-> !int_out)
    else $error("interrupt survives timer reset");
  AST_QUIET_AFTER_RESET: assert property ($rose(arst_n) |-> !int_out && !sda_oe)
    else $error("outputs active after reset");
  cover property ($rose(int_out));
  cover property ($fell(int_out));
  cover property ($rose(sda_oe));
endmodule

bind wmt_top wmt_top_asserts u_chk (.clock(clock), .arst_n(arst_n), .osc_in(osc_in),
  .tmr_rst_n(tmr_rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe(sda_oe), .int_out(int_out));

// ==== wmt_top_tb_top.sv ====
// testbench: wake-up match timer against the bus host model
`timescale 1ns/100ps
`include "wmt_map.vh"
module wmt_top_tb_top;
  reg         clock, arst_n, osc_in, tmr_rst_n;
  wire        scl, sda_m, sda_oe, sda_out, int_out;
  wire        sda_w = sda_m & ~sda_oe;
  int         n_mismatch = 0, compares = 0, n_osc = 0;
  logic       ack;
  logic [7:0] q;
  wmt_top dut (.clock(clock), .arst_n(arst_n), .osc_in(osc_in), .tmr_rst_n(tmr_rst_n),
    .scl_in(scl), .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out));
  wmt_host host (.sda_w(sda_w), .scl(scl), .sda_m(sda_m));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // oscillator scaled to 25 ns so one second fits the run; edges miss clock edges
  initial begin
    osc_in = 1'b0;
    #7;
    forever #12.5 osc_in = ~osc_in;
  end
  always @(posedge osc_in) n_osc = n_osc + 1;
  task cmp(input string nm, input logic [23:0] e, input logic [23:0] g);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task test_done;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [23:0] d, input logic ea);
    host.start();
    host.xbyte(a, 1'b1, q, ack);
    cmp("addr_ack", ea, ack);
    for (int i = 2; ea && i >= 0; i--) begin
      host.xbyte(d[i*8 +: 8], 1'b1, q, ack);
      cmp("data_ack", 1'b1, ack);
    end
    host.stop();
  endtask
  task t_reset;
    @(negedge clock);
    cmp("int_idle", 1'b0, int_out);
    cmp("oe_idle", 1'b0, sda_oe);
  endtask
  task t_wrong_addr;
    wr({`WMT_I2C_ADDR ^ 7'h01, 1'b0}, 24'h000000, 1'b0);
  endtask
  task t_write;
    wr({`WMT_I2C_ADDR, 1'b0}, 24'h000001, 1'b1);
  endtask
  // start, short bounce mid-second, then match at one second
  task t_count;
    @(posedge clock) tmr_rst_n <= 1'b1;
    n_osc = 0;
    wait (n_osc == 16000);
    @(posedge clock) tmr_rst_n <= 1'b0;
    repeat (6) @(posedge clock);
    tmr_rst_n <= 1'b1;
    wait (n_osc == 32760);
    cmp("int_early", 1'b0, int_out);
    wait (int_out === 1'b1 || n_osc == 32800);
    @(negedge clock);
    cmp("int_on_second", 1'b1, n_osc >= 32768 && n_osc <= 32780);
    cmp("int_raised", 1'b1, int_out);
  endtask
  task t_read;
    host.start();
    host.xbyte({`WMT_I2C_ADDR, 1'b1}, 1'b1, q, ack);
    cmp("rd_ack", 1'b1, ack);
    host.xbyte(8'hff, 1'b0, q, ack);
    cmp("rd_byte_hi", 8'h00, q);
    host.xbyte(8'hff, 1'b0, q, ack);
    cmp("rd_byte_mid", 8'h00, q);
    host.xbyte(8'hff, 1'b1, q, ack);
    cmp("rd_byte_lo", 8'h01, q);
    host.stop();
    @(negedge clock);
    cmp("int_cleared", 1'b0, int_out);
  endtask
  initial begin
    arst_n = 1'b0;
    tmr_rst_n = 1'b0;
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    t_reset();
    t_wrong_addr();
    t_write();
    t_count();
    t_read();
    test_done();
  end
  // tests need about 83k cycles; limit kept below 100k
  initial begin
    #950000;
    n_mismatch++;
    test_done();
  end
endmodule
